// ===== verilog/uart_baud_divisor_regs.sv
// baud divisor registers, shared frame-control location and bit-rate divider
//
// Notes on behaviour
// - divisor is 12 bits: high register gives bits 11:8, low gives 7:0.
// - high divisor shares its address with frame control; select bit routes writes, read order routes reads.
// - reading the high divisor returns zero in the select bit.
// - writing the low byte reloads the prescaler at once with full divisor.
// - double speed in asynchronous mode divides prescaler tick by 8, not 16.
// - double speed has no effect in synchronous mode.
// - frame control reads select as one; writes with select one update it.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module uart_baud_divisor_regs (
  input  wire logic                         I_MCLK,
  input  wire logic                         I_RSTN,
  input  wire logic [ubdr_pkg::ADDR_W-1:0]  I_ADDR,
  input  wire logic [ubdr_pkg::DATA_W-1:0]  I_WDATA,
  input  wire logic                         I_WR,
  input  wire logic                         I_RD,
  input  wire logic                         I_DOUBLE_SPEED,
  output logic      [ubdr_pkg::DATA_W-1:0]  O_RDATA,
  output logic      [ubdr_pkg::DIV_W-1:0]   O_DIVISOR,
  output logic      [ubdr_pkg::FCTL_W-1:0]  O_FRAME_CTRL,
  output logic                              O_SYNC_MODE,
  output logic                              O_PRESC_TICK,
  output logic                              O_BIT_TICK
);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [ubdr_pkg::DATA_W-1:0] baud_divisor_low_reg;
  logic [ubdr_pkg::DATA_W-1:0] baud_divisor_low_next;
  logic [ubdr_pkg::HIGH_W-1:0] baud_divisor_high_reg;
  logic [ubdr_pkg::HIGH_W-1:0] baud_divisor_high_next;
  logic [ubdr_pkg::FCTL_W-1:0] frame_control_c_reg;
  logic [ubdr_pkg::FCTL_W-1:0] frame_control_c_next;
  logic [ubdr_pkg::DATA_W-1:0] rdata_reg;
  logic [ubdr_pkg::DATA_W-1:0] rdata_next;
  logic                        shared_read_last_reg;
  logic                        shared_read_last_next;
  logic [ubdr_pkg::BCNT_W-1:0] bit_cnt_reg;
  logic [ubdr_pkg::BCNT_W-1:0] bit_cnt_next;
  logic [ubdr_pkg::BCNT_W-1:0] bit_last_reg;
  logic                        bit_tick_reg;
  logic                        bit_tick_next;

  ubdr_presc_if presc_bus ();

  // ---------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------
  wire hit_low    = (I_ADDR == ubdr_pkg::BAUD_LOW_ADDR);
  wire hit_shared = (I_ADDR == ubdr_pkg::SHARED_ADDR);

  wire wr_low     = I_WR & hit_low;
  wire wr_shared  = I_WR & hit_shared;
  wire rd_low     = I_RD & hit_low;
  wire rd_shared  = I_RD & hit_shared;

  wire shared_location_select = I_WDATA[ubdr_pkg::SEL_BIT];

  // the select bit in the written byte picks the target
  wire wr_high    = wr_shared & ~shared_location_select;
  wire wr_fctl    = wr_shared &  shared_location_select;

  // ---------------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------------
  assign baud_divisor_low_next  = wr_low ? I_WDATA : baud_divisor_low_reg;

  // bits 6:4 are reserved and dropped, so they always read back zero
  assign baud_divisor_high_next = wr_high ? I_WDATA[ubdr_pkg::HIGH_MSB:ubdr_pkg::HIGH_LSB]
                                          : baud_divisor_high_reg;

  assign frame_control_c_next   = wr_fctl ? I_WDATA[ubdr_pkg::FCTL_W-1:0]
                                          : frame_control_c_reg;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      baud_divisor_low_reg  <= ubdr_pkg::BAUD_LOW_RESET;
      baud_divisor_high_reg <= ubdr_pkg::BAUD_HIGH_RESET;
      frame_control_c_reg   <= ubdr_pkg::FCTL_RESET;
    end else begin
      baud_divisor_low_reg  <= baud_divisor_low_next;
      baud_divisor_high_reg <= baud_divisor_high_next;
      frame_control_c_reg   <= frame_control_c_next;
    end
  end

  // ---------------------------------------------------------------------
  // prescaler reload
  // ---------------------------------------------------------------------
  // the new low byte is taken straight from the bus so the reload
  // carries the complete new value in the same edge as the store.
  // writing only the high byte leaves the running period alone.
  wire [ubdr_pkg::DIV_W-1:0] baud_divisor_value = {baud_divisor_high_reg, baud_divisor_low_reg};
  wire [ubdr_pkg::DIV_W-1:0] reload_value       = {baud_divisor_high_reg, I_WDATA};

  assign presc_bus.divisor = wr_low ? reload_value : baud_divisor_value;
  assign presc_bus.reload  = wr_low;

  ubdr_prescaler u_prescaler (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RSTN),
    .presc   (presc_bus)
  );

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  // a read cannot carry a select bit, so a second read of the shared
  // location in the very next cycle returns frame control; any single
  // read returns the divisor high byte.
  wire second_shared_read = rd_shared & shared_read_last_reg;

  wire [ubdr_pkg::DATA_W-1:0] high_rdata = {1'b0, 3'h0, baud_divisor_high_reg};
  wire [ubdr_pkg::DATA_W-1:0] fctl_rdata = {1'b1, frame_control_c_reg};

  wire [ubdr_pkg::DATA_W-1:0] shared_rdata = second_shared_read ? fctl_rdata : high_rdata;

  assign rdata_next = rd_low    ? baud_divisor_low_reg :
                      rd_shared ? shared_rdata :
                      I_RD      ? ubdr_pkg::UNMAPPED_RDATA :
                                  ubdr_pkg::RDATA_RESET;

  // the pair resets after the frame-control read, so a third read
  // back to back starts a new pair with the high byte
  assign shared_read_last_next = rd_shared & ~shared_read_last_reg;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_reg            <= ubdr_pkg::RDATA_RESET;
      shared_read_last_reg <= 1'b0;
    end else begin
      rdata_reg            <= rdata_next;
      shared_read_last_reg <= shared_read_last_next;
    end
  end

  // ---------------------------------------------------------------------
  // bit-rate divider on the prescaler tick
  // ---------------------------------------------------------------------
  wire sync_mode = frame_control_c_reg[ubdr_pkg::MODE_BIT];

  // double speed only counts in asynchronous mode
  wire double_active = I_DOUBLE_SPEED & ~sync_mode;

  wire [ubdr_pkg::BCNT_W-1:0] bit_last =
    sync_mode     ? ubdr_pkg::SYNC_LAST :
    double_active ? ubdr_pkg::ASYNC_DOUBLE_LAST :
                    ubdr_pkg::ASYNC_NORMAL_LAST;

  // restart the phase on reload or rate change; a frame in flight
  // is not shielded from either
  wire bit_restart = presc_bus.reload | (bit_last != bit_last_reg);
  wire bit_wrap    = presc_bus.tick & (bit_cnt_reg == bit_last_reg);

  assign bit_cnt_next  = bit_restart      ? ubdr_pkg::BCNT_RESET :
                         bit_wrap         ? ubdr_pkg::BCNT_RESET :
                         presc_bus.tick   ? bit_cnt_reg + 4'h1 :
                                            bit_cnt_reg;
  assign bit_tick_next = bit_wrap & ~bit_restart;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      bit_cnt_reg  <= ubdr_pkg::BCNT_RESET;
      bit_last_reg <= ubdr_pkg::ASYNC_NORMAL_LAST;
      bit_tick_reg <= 1'b0;
    end else begin
      bit_cnt_reg  <= bit_cnt_next;
      bit_last_reg <= bit_last;
      bit_tick_reg <= bit_tick_next;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign O_RDATA      = rdata_reg;
  assign O_DIVISOR    = baud_divisor_value;
  assign O_FRAME_CTRL = frame_control_c_reg;
  assign O_SYNC_MODE  = sync_mode;
  assign O_PRESC_TICK = presc_bus.tick;
  assign O_BIT_TICK   = bit_tick_reg;

endmodule : uart_baud_divisor_regs

// ===== verilog/ubdr_pkg.sv
// constants for the baud divisor register block
package ubdr_pkg;
  localparam int unsigned ADDR_W  = 6;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned DIV_W   = 12;
  localparam int unsigned HIGH_W  = 4;
  localparam int unsigned FCTL_W  = 7;
  localparam int unsigned BCNT_W  = 4;

  // i/o locations
  localparam logic [ADDR_W-1:0] BAUD_LOW_ADDR = 6'h09;
  localparam logic [ADDR_W-1:0] SHARED_ADDR   = 6'h20;

  // field positions in the byte
  localparam int unsigned SEL_BIT     = 7;
  localparam int unsigned MODE_BIT    = 6;
  localparam int unsigned HIGH_LSB    = 0;
  localparam int unsigned HIGH_MSB    = 3;

  // reset values
  localparam logic [DATA_W-1:0] BAUD_LOW_RESET  = 8'h00;
  localparam logic [HIGH_W-1:0] BAUD_HIGH_RESET = 4'h0;
  localparam logic [FCTL_W-1:0] FCTL_RESET      = 7'h06;
  localparam logic [DIV_W-1:0]  PRESC_RESET     = 12'h000;
  localparam logic [DATA_W-1:0] RDATA_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA  = 8'h00;

  // bit-rate dividers applied to the prescaler tick, stored as count-1
  localparam logic [BCNT_W-1:0] ASYNC_NORMAL_LAST = 4'hF;
  localparam logic [BCNT_W-1:0] ASYNC_DOUBLE_LAST = 4'h7;
  localparam logic [BCNT_W-1:0] SYNC_LAST         = 4'h1;
  localparam logic [BCNT_W-1:0] BCNT_RESET        = 4'h0;
endpackage : ubdr_pkg

// ===== verilog/ubdr_presc_if.sv
// carrier between the register logic and the baud prescaler
`timescale 1ns/100ps
interface ubdr_presc_if;
  logic [ubdr_pkg::DIV_W-1:0] divisor;
  logic                       reload;
  logic                       tick;

  modport ctrl  (output divisor, output reload, input tick);
  modport presc (input divisor, input reload, output tick);
endinterface : ubdr_presc_if

// ===== verilog/ubdr_prescaler.sv
// baud prescaler: down-counter reloaded from the divisor
`timescale 1ns/100ps
module ubdr_prescaler (
  input  wire logic    i_clk,
  input  wire logic    i_rst_n,
  ubdr_presc_if.presc  presc
);
  logic [ubdr_pkg::DIV_W-1:0] count_reg;
  logic [ubdr_pkg::DIV_W-1:0] count_next;
  logic                       tick_reg;
  logic                       tick_next;
  wire                        at_zero = (count_reg == ubdr_pkg::PRESC_RESET);

  // a reload overrides the running period at once
  assign count_next = presc.reload ? presc.divisor :
                      at_zero      ? presc.divisor :
                                     count_reg - 12'h001;
  // no tick on the reload cycle so a new period starts clean
  assign tick_next  = at_zero & ~presc.reload;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= ubdr_pkg::PRESC_RESET;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign presc.tick = tick_reg;
endmodule : ubdr_prescaler

// ===== dv/ubdr_monitor.sv
// assertion checker for the baud divisor register block
`timescale 1ns/100ps
module ubdr_monitor (
  input wire logic        I_MCLK,
  input wire logic        I_RSTN,
  input wire logic [5:0]  I_ADDR,
  input wire logic [7:0]  I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [7:0]  O_RDATA,
  input wire logic [11:0] O_DIVISOR,
  input wire logic [6:0]  O_FRAME_CTRL,
  input wire logic        O_SYNC_MODE,
  input wire logic        O_PRESC_TICK,
  input wire logic        O_BIT_TICK
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  wire logic shr = I_RD && I_ADDR == 6'h20;
  sequence s_first; shr && !$past(shr); endsequence
  sequence s_wlow; I_WR && I_ADDR == 6'h09 && I_WDATA != 8'h00; endsequence
  property p_rd_idle; !I_RD |=> O_RDATA == 8'h00; endproperty
  property p_rd_low; I_RD && I_ADDR == 6'h09 |=> O_RDATA == $past(O_DIVISOR[7:0]); endproperty
  property p_rd_unmap; I_RD && I_ADDR != 6'h09 && !shr |=> O_RDATA == 8'h00; endproperty
  property p_rd_high; s_first |=> O_RDATA == {4'h0, $past(O_DIVISOR[11:8])}; endproperty
  property p_rd_fctl; s_first ##1 shr |=> O_RDATA == {1'b1, $past(O_FRAME_CTRL)}; endproperty
  property p_wr_div;
    I_WR && I_ADDR == 6'h20 && !I_WDATA[7] |=> O_DIVISOR[11:8] == $past(I_WDATA[3:0]) && $stable(O_FRAME_CTRL);
  endproperty
  property p_wr_fctl;
    I_WR && I_ADDR == 6'h20 && I_WDATA[7] |=> O_FRAME_CTRL == $past(I_WDATA[6:0]) && $stable(O_DIVISOR);
  endproperty
  property p_reload; s_wlow |=> !O_PRESC_TICK && O_DIVISOR[7:0] == $past(I_WDATA); endproperty
  // a nonzero, unchanged divisor can never tick two cycles running
  property p_tick_gap; O_PRESC_TICK && O_DIVISOR != 12'h000 && $stable(O_DIVISOR) |=> !O_PRESC_TICK; endproperty
  property p_bit_tick; O_BIT_TICK |-> $past(O_PRESC_TICK); endproperty
  property p_sync; O_SYNC_MODE == O_FRAME_CTRL[6]; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_rd_low: assert property (p_rd_low) else $error("low byte read wrong");
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  a_rd_high: assert property (p_rd_high) else $error("high byte read wrong");
  a_rd_fctl: assert property (p_rd_fctl) else $error("frame control read wrong");
  a_wr_div: assert property (p_wr_div) else $error("high divisor write wrong");
  a_wr_fctl: assert property (p_wr_fctl) else $error("frame control write wrong");
  a_reload: assert property (p_reload) else $error("low write did not reload");
  a_tick_gap: assert property (p_tick_gap) else $error("prescaler ticked early");
  a_bit_tick: assert property (p_bit_tick) else $error("bit tick without prescaler tick");
  a_sync: assert property (p_sync) else $error("sync mode output wrong");
endmodule : ubdr_monitor

bind uart_baud_divisor_regs ubdr_monitor i_mon (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_DIVISOR(O_DIVISOR),
  .O_FRAME_CTRL(O_FRAME_CTRL), .O_SYNC_MODE(O_SYNC_MODE), .O_PRESC_TICK(O_PRESC_TICK), .O_BIT_TICK(O_BIT_TICK));

// ===== dv/tb_top.sv
// self-checking bench for the baud divisor register block
`timescale 1ns/100ps
module tb_top;
  logic        I_MCLK = 1'b0;
  logic        I_RSTN = 1'b0;
  logic [5:0]  I_ADDR = 6'h00;
  logic [7:0]  I_WDATA = 8'h00;
  logic        I_WR = 1'b0;
  logic        I_RD = 1'b0;
  logic        I_DOUBLE_SPEED = 1'b0;
  logic [7:0]  O_RDATA;
  logic [11:0] O_DIVISOR;
  logic [6:0]  O_FRAME_CTRL;
  logic        O_SYNC_MODE;
  logic        O_PRESC_TICK;
  logic        O_BIT_TICK;
  int          fail_count = 0;
  int          total_checks = 0;
  int          n;
  uart_baud_divisor_regs i_dut (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_DOUBLE_SPEED(I_DOUBLE_SPEED), .O_RDATA(O_RDATA), .O_DIVISOR(O_DIVISOR),
    .O_FRAME_CTRL(O_FRAME_CTRL), .O_SYNC_MODE(O_SYNC_MODE), .O_PRESC_TICK(O_PRESC_TICK), .O_BIT_TICK(O_BIT_TICK));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // op bit 0 writes, bit 1 reads, zero idles the bus
  task automatic bus(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
    @(posedge I_MCLK);
    I_WR <= op[0];
    I_RD <= op[1];
    I_ADDR <= a;
    I_WDATA <= d;
  endtask : bus
  task automatic gap;
    bus(2'h0, 6'h00, 8'h00);
    #1;
  endtask : gap
  task automatic rd_pair(input logic [7:0] e1, input logic [7:0] e2);
    bus(2'h2, 6'h20, 8'h00);
    bus(2'h2, 6'h20, 8'h00);
    #1;
    chk(O_RDATA, e1);
    gap;
    chk(O_RDATA, e2);
  endtask : rd_pair
  // bounded wait; returns edges counted until the chosen tick is seen
  task automatic count_to(input logic bt, output int c);
    c = 0;
    do begin
      @(posedge I_MCLK);
      #1;
      c++;
    end while ((bt ? O_BIT_TICK : O_PRESC_TICK) !== 1'b1 && c < 400);
  endtask : count_to
  task automatic t_reset;
    bus(2'h2, 6'h09, 8'h00);
    gap;
    chk(O_RDATA, 8'h00);
    rd_pair(8'h00, 8'h86);
  endtask : t_reset
  task automatic t_regs;
    bus(2'h1, 6'h09, 8'hA5);
    bus(2'h1, 6'h20, 8'h0C);
    bus(2'h2, 6'h09, 8'h00);
    gap;
    chk(O_RDATA, 8'hA5);
    chk(O_DIVISOR, 12'hCA5);
    rd_pair(8'h0C, 8'h86);
    bus(2'h1, 6'h20, 8'hC6);
    bus(2'h1, 6'h15, 8'hFF);
    bus(2'h2, 6'h15, 8'h00);
    gap;
    chk(O_RDATA, 8'h00);
    chk(O_DIVISOR, 12'hCA5);
    chk(O_SYNC_MODE, 1'b1);
    rd_pair(8'h0C, 8'hC6);
    bus(2'h1, 6'h20, 8'h86);
  endtask : t_regs
  // no frames exist here, so divisor changes are safe at any time
  task automatic t_reload;
    bus(2'h1, 6'h20, 8'h01);
    bus(2'h1, 6'h09, 8'h02);
    gap;
    count_to(1'b0, n);
    chk(12'(n), 12'd259);
    count_to(1'b0, n);
    chk(12'(n), 12'd259);
    bus(2'h1, 6'h20, 8'h00);
    bus(2'h1, 6'h09, 8'h05);
    gap;
    count_to(1'b0, n);
    chk(12'(n), 12'd6);
  endtask : t_reload
  task automatic t_rate;
    int nexp[4] = '{16, 8, 2, 2};
    bus(2'h1, 6'h09, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(2'h1, 6'h20, i[1] ? 8'hC6 : 8'h86);
      I_DOUBLE_SPEED <= i[0];
      gap;
      count_to(1'b1, n);
      count_to(1'b1, n);
      chk(12'(n), 12'(nexp[i]));
    end
  endtask : t_rate
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    forever #5 I_MCLK = ~I_MCLK;
  end
  initial begin
    repeat (3) @(posedge I_MCLK);
    I_RSTN <= 1'b1;
    t_reset;
    t_regs;
    t_reload;
    t_rate;
    tally_and_finish;
  end
  // whole run needs about 600 cycles
  initial begin
    repeat (10000) @(posedge I_MCLK);
    fail_count++;
    tally_and_finish;
  end
endmodule : tb_top
